/* File: rtl/csp_consts.vh */
// register map, field positions and timing constants of the signature / self-test block
`ifndef CSP_CONSTS_VH
`define CSP_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSP_OFF_MISC 12'h000
`define CSP_OFF_DPOST 12'h004
`define CSP_OFF_STAT 12'h008
`define CSP_OFF_MASK 12'h00c
`define CSP_OFF_CTRL 12'h010
`define CSP_OFF_RUN 12'h014

// ----------------------------------------
// misc_settings fields
// ----------------------------------------
`define CSP_MISC_TIMER 0
`define CSP_MISC_ERRMODE 1
`define CSP_MISC_RST 32'h0000_0000
`define CSP_MISC_MASK 32'h0000_0003

// ----------------------------------------
// digital_selftest_disables fields
// ----------------------------------------
`define CSP_DP_ALL 0
`define CSP_DP_XTAL0_ST 7
`define CSP_DP_XTAL1_ST 8
`define CSP_DP_FREQ_LO 9
`define CSP_DP_FREQ_HI 20
`define CSP_DP_XSW 21
`define CSP_DP_DUAL 22
`define CSP_DP_SIG 23
`define CSP_DP_RST 32'h0000_0002
`define CSP_DP_MASK 32'h00ff_ffff

// ----------------------------------------
// status bits
// ----------------------------------------
`define CSP_ST_FAIL 0
`define CSP_ST_RELOAD 1
`define CSP_ST_DONE 2

// ----------------------------------------
// timing
// ----------------------------------------
`define CSP_CHECK_MS 10
`define CSP_CLK_MHZ 200
`define CSP_CHECK_CYC (`CSP_CHECK_MS * 1000 * `CSP_CLK_MHZ)

`endif

/* File: rtl/csp_sig_post.v */
// configuration signature check and power-on self-test control
`timescale 1ns/1ps
`include "csp_consts.vh"

// What this block does
// [R1] error action zero: mismatch sets failure flag
// [R2] software enables failure-to-fault path itself
// [R3] error action one: reload flag, outputs off
// [R4] software enables reload interrupt itself
// [R5] interval zero off, one checks every 10ms
// [R6] bit 23 skips signature monitor self test
// [R7] bit 22 skips dual crystal failure test
// [R8] bit 21 skips crystal switching test
// [R9] bits 20:9 skip per-output frequency test
// [R10] no monitor selects: frequency test skipped
// [R11] software disables unmonitored outputs' tests
// [R12] bits 8 and 7 skip crystal short-term tests
// [R13] bit 0 disables every digital self test
// [R14] failure and reload flags sticky until cleared
module csp_sig_post #(
	parameter CHECK_CYC = `CSP_CHECK_CYC,
	parameter NOUT = 12
) (
	// clock and reset
	input wire mclk_i,
	input wire rst_b_i,
	// apb slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output wire pslverr_o,
	output reg [31:0] prdata_o,
	// device state inputs (asynchronous)
	input wire por_start_i,
	input wire sig_mismatch_i,
	input wire reload_done_i,
	input wire xtal0_en_i,
	input wire xtal1_en_i,
	input wire los_cfg_ok_i,
	input wire st_cfg_ok_i,
	input wire [NOUT-1:0] freq_out_sel_i,
	input wire [NOUT-1:0] freq_outb_sel_i,
	// self-test run enables and control outputs
	output reg sig_post_run_o,
	output reg dual_post_run_o,
	output reg xsw_post_run_o,
	output reg [NOUT-1:0] freq_post_run_o,
	output reg xtal0_st_run_o,
	output reg xtal1_st_run_o,
	output reg outputs_off_o,
	output reg reload_req_o,
	output reg sig_check_o,
	output wire fault_o,
	output wire irq_o
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam NSYNC = 8 + 2 * NOUT;
	wire [NSYNC-1:0] async_in;
	reg [NSYNC-1:0] sync1_q;
	reg [NSYNC-1:0] sync2_q;
	assign async_in = {freq_outb_sel_i, freq_out_sel_i, st_cfg_ok_i, los_cfg_ok_i,
		xtal1_en_i, xtal0_en_i, reload_done_i, sig_mismatch_i, por_start_i, 1'b0};

	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_q <= {NSYNC{1'b0}};
			sync2_q <= {NSYNC{1'b0}};
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	wire por_s = sync2_q[1];
	wire mism_s = sync2_q[2];
	wire rdone_s = sync2_q[3];
	wire x0_s = sync2_q[4];
	wire x1_s = sync2_q[5];
	wire los_s = sync2_q[6];
	wire st_s = sync2_q[7];
	wire [NOUT-1:0] osel_s = sync2_q[8 +: NOUT];
	wire [NOUT-1:0] obsel_s = sync2_q[8 + NOUT +: NOUT];

	// ----------------------------------------
	// apb register file
	// ----------------------------------------
	reg [31:0] misc_q;
	reg [31:0] dpost_q;
	reg [2:0] stat_q;
	reg [2:0] mask_q;
	reg fault_en_q;
	reg por_q;
	reg mism_q;
	reg [7:0] run_stat;

	wire wr = psel_i & penable_i & pwrite_i;
	wire rd = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;

	function hit;
		input [11:0] a;
		input [11:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	wire known = hit(paddr_i, `CSP_OFF_MISC) | hit(paddr_i, `CSP_OFF_DPOST) |
		hit(paddr_i, `CSP_OFF_STAT) | hit(paddr_i, `CSP_OFF_MASK) |
		hit(paddr_i, `CSP_OFF_CTRL) | hit(paddr_i, `CSP_OFF_RUN);
	assign pslverr_o = psel_i & penable_i & ~known;

	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			misc_q <= `CSP_MISC_RST;
			dpost_q <= `CSP_DP_RST;
			mask_q <= 3'h0;
			fault_en_q <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			if (wr && hit(paddr_i, `CSP_OFF_MISC))
				misc_q <= pwdata_i & `CSP_MISC_MASK;
			if (wr && hit(paddr_i, `CSP_OFF_DPOST))
				dpost_q <= pwdata_i & `CSP_DP_MASK;
			if (wr && hit(paddr_i, `CSP_OFF_MASK))
				mask_q <= pwdata_i[2:0];
			if (wr && hit(paddr_i, `CSP_OFF_CTRL))
				fault_en_q <= pwdata_i[0];
			if (psel_i && !penable_i && !pwrite_i) begin
				// data registered in setup so it is stable in the access cycle
				case (1'b1)
				hit(paddr_i, `CSP_OFF_MISC): prdata_o <= misc_q;
				hit(paddr_i, `CSP_OFF_DPOST): prdata_o <= dpost_q;
				hit(paddr_i, `CSP_OFF_STAT): prdata_o <= {29'h0, stat_q};
				hit(paddr_i, `CSP_OFF_MASK): prdata_o <= {29'h0, mask_q};
				hit(paddr_i, `CSP_OFF_CTRL): prdata_o <= {31'h0, fault_en_q};
				hit(paddr_i, `CSP_OFF_RUN): prdata_o <= {24'h0, run_stat};
				default: prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// periodic signature check
	// ----------------------------------------
	localparam S_IDLE = 3'b001;
	localparam S_WAIT = 3'b010;
	localparam S_RELOAD = 3'b100;
	reg [2:0] state_q;
	reg [31:0] tmr_q;
	wire tick = (tmr_q == CHECK_CYC - 1);
	wire mism_rise = mism_s & ~mism_q;
	wire err_fail = mism_rise & (state_q == S_WAIT) & ~misc_q[`CSP_MISC_ERRMODE];
	wire err_reload = mism_rise & (state_q == S_WAIT) & misc_q[`CSP_MISC_ERRMODE];
	wire post_go = por_s & ~por_q;
	wire rd_stat = rd & hit(paddr_i, `CSP_OFF_STAT);

	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= S_IDLE;
			tmr_q <= 32'h0;
			sig_check_o <= 1'b0;
			outputs_off_o <= 1'b0;
			reload_req_o <= 1'b0;
			mism_q <= 1'b0;
			por_q <= 1'b0;
		end else begin
			mism_q <= mism_s;
			por_q <= por_s;
			sig_check_o <= 1'b0;
			case (state_q)
			S_IDLE: begin
				tmr_q <= 32'h0;
				if (misc_q[`CSP_MISC_TIMER]) // R5
					state_q <= S_WAIT;
			end
			S_WAIT: begin
				if (!misc_q[`CSP_MISC_TIMER]) begin // R5
					state_q <= S_IDLE;
				end else if (err_reload) begin
					state_q <= S_RELOAD; // R3
					outputs_off_o <= 1'b1; // R3
					reload_req_o <= 1'b1; // R3
				end else if (tick) begin
					tmr_q <= 32'h0;
					sig_check_o <= 1'b1; // R5
				end else begin
					tmr_q <= tmr_q + 32'h1;
				end
			end
			S_RELOAD: begin
				// outputs stay off until the reload and restart complete
				if (rdone_s) begin
					outputs_off_o <= 1'b0;
					reload_req_o <= 1'b0;
					state_q <= S_IDLE;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// sticky status and interrupt
	// ----------------------------------------
	wire [2:0] ev = {post_go, err_reload, err_fail};
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			stat_q <= 3'h0;
		else
			stat_q <= (rd_stat ? 3'h0 : stat_q) | ev; // R1 R3 R14
	end
	assign irq_o = |(stat_q & mask_q);
	assign fault_o = fault_en_q & stat_q[`CSP_ST_FAIL]; // R1

	// ----------------------------------------
	// self-test run selection
	// ----------------------------------------
	// a test launches on the trigger unless the master or its own disable is set
	function may_run;
		input trig;
		input master_off;
		input own_off;
		begin
			may_run = trig & ~master_off & ~own_off;
		end
	endfunction

	wire all_off = dpost_q[`CSP_DP_ALL]; // R13
	wire both_x = x0_s & x1_s;
	wire any_sel = |(osel_s | obsel_s); // R10
	wire [NOUT-1:0] fdis = dpost_q[`CSP_DP_FREQ_HI:`CSP_DP_FREQ_LO]; // R9

	// crystal tests need both crystals plus their monitor set up
	wire los_ready = both_x & los_s;
	wire st_ready = both_x & st_s;

	wire sig_run_d = may_run(post_go, all_off, dpost_q[`CSP_DP_SIG]); // R6
	wire dual_run_d = may_run(post_go, all_off, dpost_q[`CSP_DP_DUAL]) & los_ready; // R7
	wire xsw_run_d = may_run(post_go, all_off, dpost_q[`CSP_DP_XSW]) & los_ready; // R8
	wire x0_run_d = may_run(post_go, all_off, dpost_q[`CSP_DP_XTAL0_ST]) & st_ready; // R12
	wire x1_run_d = may_run(post_go, all_off, dpost_q[`CSP_DP_XTAL1_ST]) & st_ready; // R12
	// software must disable outputs it does not monitor; not checked here
	wire [NOUT-1:0] freq_run_d;

	// per-output frequency tests; no selected monitor at all skips every one
	genvar gi;
	generate
		for (gi = 0; gi < NOUT; gi = gi + 1) begin : g_freq
			assign freq_run_d[gi] = may_run(post_go, all_off, fdis[gi]) & any_sel; // R9 R10
		end
	endgenerate

	// ----------------------------------------
	// launch pulses
	// ----------------------------------------
	// the trigger is an edge of a synchronised level, so a second one
	// cannot follow at once: every pulse is exactly one cycle wide
	// signature monitor test
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sig_post_run_o <= 1'b0;
		end else begin
			sig_post_run_o <= sig_run_d; // R6 R13
		end
	end

	// dual crystal failure test
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dual_post_run_o <= 1'b0;
		end else begin
			dual_post_run_o <= dual_run_d; // R7 R13
		end
	end

	// crystal switching test
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xsw_post_run_o <= 1'b0;
		end else begin
			xsw_post_run_o <= xsw_run_d; // R8 R13
		end
	end

	// crystal zero short-term test
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xtal0_st_run_o <= 1'b0;
		end else begin
			xtal0_st_run_o <= x0_run_d; // R12 R13
		end
	end

	// crystal one short-term test
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xtal1_st_run_o <= 1'b0;
		end else begin
			xtal1_st_run_o <= x1_run_d; // R12 R13
		end
	end

	// per-output frequency tests
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			freq_post_run_o <= {NOUT{1'b0}};
		end else begin
			freq_post_run_o <= freq_run_d; // R9 R10
		end
	end

	// ----------------------------------------
	// run status copy
	// ----------------------------------------
	// the pulses are gone long before software can read them, so a copy is
	// taken one cycle after the trigger and held until the next trigger;
	// reading it has no side effect
	reg launch_q;
	reg [5:0] runst_q;
	wire [5:0] launch_vec = {xtal1_st_run_o, xtal0_st_run_o, |freq_post_run_o,
		xsw_post_run_o, dual_post_run_o, sig_post_run_o};

	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			launch_q <= 1'b0;
			runst_q <= 6'h00;
		end else begin
			launch_q <= post_go;
			if (launch_q)
				runst_q <= launch_vec;
		end
	end

	always @* begin
		run_stat = {2'b00, runst_q};
	end

endmodule

/* File: tb/csp_sig_post_chk.sv */
// port checker for the signature / self-test block
`timescale 1ns/1ps
`include "csp_consts.vh"
module csp_sig_post_chk #(
	parameter NOUT = 12
) (
	// grouped to keep the checker short
	input wire mclk_i, rst_b_i, psel_i, penable_i, pwrite_i,
	input wire [11:0] paddr_i,
	input wire xtal0_en_i, xtal1_en_i, los_cfg_ok_i, st_cfg_ok_i,
	input wire [NOUT-1:0] freq_out_sel_i, freq_outb_sel_i, freq_post_run_o,
	input wire sig_post_run_o, dual_post_run_o, xsw_post_run_o, xtal0_st_run_o,
	input wire outputs_off_o, reload_req_o, sig_check_o, fault_o, irq_o
);
	// only a status read or a mask / ctrl write may drop a flag-driven output
	wire clr = psel_i && penable_i && ((!pwrite_i && paddr_i == `CSP_OFF_STAT) ||
		(pwrite_i && (paddr_i == `CSP_OFF_MASK || paddr_i == `CSP_OFF_CTRL)));
	wire both = xtal0_en_i && xtal1_en_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	AST_FAIL_STICKY: assert property ($fell(fault_o) |-> $past(clr)) else $error("fault dropped");
	AST_IRQ_STICKY: assert property ($fell(irq_o) |-> $past(clr)) else $error("irq dropped");
	AST_RELOAD_OFF: assert property (reload_req_o == outputs_off_o) else $error("reload/off split");
	AST_CHECK_GAP: assert property (sig_check_o |=> !sig_check_o [*8]) else $error("check gap");
	AST_SIG_PULSE: assert property (sig_post_run_o |=> !sig_post_run_o) else $error("sig run");
	AST_DUAL_PRE: assert property (dual_post_run_o |-> both && los_cfg_ok_i) else $error("dual");
	AST_XSW_PRE: assert property (xsw_post_run_o |-> both && los_cfg_ok_i) else $error("xsw");
	AST_FREQ_PULSE: assert property (|freq_post_run_o |=> freq_post_run_o == 0) else $error("freq");
	AST_FREQ_AUTO: assert property ((freq_out_sel_i == 0 && freq_outb_sel_i == 0) [*6]
		|-> freq_post_run_o == 0) else $error("freq auto skip");
	AST_X0_PRE: assert property (xtal0_st_run_o |-> both && st_cfg_ok_i) else $error("x0 st");
	cover property (reload_req_o);
	cover property (sig_check_o);
	cover property (|freq_post_run_o);
endmodule
bind csp_sig_post csp_sig_post_chk #(.NOUT(NOUT)) u_chk (.*);

/* File: tb/csp_sig_post_tb.sv */
// register-level testbench of the signature / self-test block
`timescale 1ns/1ps
module csp_sig_post_tb;
	logic mclk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
	logic por_start_i = 0, sig_mismatch_i = 0, reload_done_i = 0;
	logic xtal0_en_i = 1, xtal1_en_i = 1, los_cfg_ok_i = 1, st_cfg_ok_i = 1;
	logic [11:0] paddr_i = 0, freq_out_sel_i = 12'hfff, freq_outb_sel_i = 12'hfff;
	logic [31:0] pwdata_i = 0, q;
	wire pready_o, pslverr_o, sig_post_run_o, dual_post_run_o, xsw_post_run_o, xtal0_st_run_o;
	wire xtal1_st_run_o, outputs_off_o, reload_req_o, sig_check_o, fault_o, irq_o;
	wire [31:0] prdata_o;
	wire [11:0] freq_post_run_o;
	int err_total = 0, comparisons = 0, n;
	// disable word and expected run-status bits per power-on trigger
	logic [31:0] dpv [10] = '{0, 1, 32'h800000, 32'h400000, 32'h200000, 32'h1ffe00,
		32'h1fe00, 32'h80, 32'h100, 0};
	logic [5:0] ev [10] = '{6'h3f, 0, 6'h3e, 6'h3d, 6'h3b, 6'h37, 6'h3f, 6'h2f, 6'h17, 6'h37};
	csp_sig_post #(.CHECK_CYC(50)) u_dut (.*);
	always #2.5 mclk_i = ~mclk_i;
	task acc(input [11:0] a, input w, input [31:0] d);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i) penable_i <= 1;
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		@(posedge mclk_i);
	endtask
	task ck(input string s, input [31:0] x, input [31:0] g);
		comparisons++;
		if (g !== x) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, x, g);
		end
	endtask
	task rdc(input string s, input [11:0] a, input [31:0] x);
		acc(a, 0, 0);
		ck(s, x, q);
	endtask
	// 0 trigger, 1 mismatch, 2 reload done
	task pulse(input int k);
		if (k == 0) por_start_i <= 1;
		else if (k == 1) sig_mismatch_i <= 1;
		else reload_done_i <= 1;
		repeat (5) @(posedge mclk_i);
		por_start_i <= 0;
		sig_mismatch_i <= 0;
		reload_done_i <= 0;
		repeat (8) @(posedge mclk_i);
	endtask
	task cnt;
		n = 0;
		repeat (120) begin
			@(posedge mclk_i);
			n += (sig_check_o === 1'b1);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1;
		@(posedge mclk_i);
		rdc("misc reset", 0, 0);
		rdc("dpost reset", 4, 2);
		acc(12'h018, 0, 0);
		ck("slverr", 1, e);
		ck("unmapped data", 0, q);
		acc(4, 1, '1);
		rdc("dpost reserved", 4, 32'h00ffffff);
		acc(0, 1, '1);
		rdc("misc reserved", 0, 3);
		acc(0, 1, 0);
		for (int i = 0; i < 10; i++) begin
			if (i == 9) xtal1_en_i <= 0;
			if (i == 8) freq_out_sel_i <= 0;
			if (i == 8) freq_outb_sel_i <= 0;
			acc(4, 1, dpv[i]);
			pulse(0);
			rdc("run status", 12'h014, i == 9 ? 6'h01 : ev[i]);
		end
		rdc("post flag", 8, 4);
		xtal1_en_i <= 1;
		cnt;
		ck("checks off", 0, n);
		acc(0, 1, 1);
		cnt;
		ck("checks on", 2, n);
		acc(12'h00c, 1, 1);
		acc(12'h010, 1, 1);
		pulse(1);
		ck("fault", 1, fault_o);
		ck("irq fail", 1, irq_o);
		rdc("stat fail", 8, 1);
		ck("fault clr", 0, fault_o);
		acc(0, 1, 3);
		acc(12'h00c, 1, 0);
		pulse(1);
		ck("reload req", 1, reload_req_o);
		ck("outputs off", 1, outputs_off_o);
		ck("irq masked", 0, irq_o);
		acc(12'h00c, 1, 2);
		ck("irq reload", 1, irq_o);
		pulse(2);
		ck("reload end", 0, outputs_off_o);
		rdc("stat reload", 8, 2);
		give_verdict;
	end
endmodule
